// ==== rtl/rpta_pkg.sv ====
package rpta_pkg;
   localparam int NPORT = 65;
   localparam int VID_W = 12;
   localparam int NVID = 4096;
   localparam int GRP_W = 16;
   localparam int FID_W = 17;
   localparam int LP_W = 7;
   localparam int NID = 16;
   localparam int NAGG = 16;
   localparam int MAC_AW = 6;
   localparam int NMAC = 64;
   localparam int ADDR_W = 8;
   localparam logic [FID_W-1:0] FID_UNUSED = 17'h1ffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------
   // register word indices (byte address = 4 * index)
   // ----------------------------------------------
   localparam logic [5:0] R_CTRL = 6'h00;
   localparam logic [5:0] R_STATUS = 6'h01;
   localparam logic [5:0] R_RANGE = 6'h02;
   localparam logic [5:0] R_UGRP = 6'h03;
   localparam logic [5:0] R_USET = 6'h04;
   localparam logic [5:0] R_USEL = 6'h07;
   localparam logic [5:0] R_FPORT = 6'h0a;
   localparam logic [5:0] R_EID = 6'h0d;
   localparam logic [5:0] R_ID = 6'h0e;
   localparam logic [5:0] R_VSEL = 6'h1e;
   localparam logic [5:0] R_VGRP = 6'h1f;
   localparam logic [5:0] R_VPORT = 6'h20;
   localparam logic [5:0] R_VFID = 6'h23;
   localparam logic [5:0] R_PSEL = 6'h24;
   localparam logic [5:0] R_PCFG = 6'h25;
   localparam logic [5:0] R_ASEL = 6'h26;
   localparam logic [5:0] R_AMASK = 6'h27;
   localparam logic [5:0] R_FWDEN = 6'h2a;
   localparam logic [5:0] R_LRNEN = 6'h2d;
   localparam logic [5:0] R_MSEL = 6'h30;
   localparam logic [5:0] R_MENT = 6'h31;
   localparam logic [5:0] R_FCNT = 6'h32;
   localparam logic [5:0] R_LAST = 6'h32;
   // ----------------------------------------------
   // field positions and reset values
   // ----------------------------------------------
   localparam int C_UPD_GO = 0;
   localparam int C_OP_GO = 1;
   localparam int C_LIST = 2;
   localparam int C_BYID = 3;
   localparam int C_BYPORT = 4;
   localparam int C_REMOVE = 5;
   localparam int C_GRP = 6;
   localparam int C_IRQ = 7;
   localparam int S_FDONE = 0;
   localparam int S_UDONE = 1;
   localparam int RANGE_END_LSB = 16;
   localparam int PCFG_EG_LSB = 16;
   localparam logic [VID_W-1:0] UPD_END_RST = 12'hfff;
   localparam logic [NPORT-1:0] MASK_RST = 65'h1_ffff_ffff_ffff_ffff;
   typedef enum logic {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} rpta_eng_t;
   typedef struct packed {
      logic valid;
      logic [LP_W-1:0] port;
      logic [FID_W-1:0] fid;
      logic [MAC_AW-1:0] slot;
   } rpta_learn_t;
   typedef struct packed {
      logic valid;
      logic [LP_W-1:0] lport;
      logic [FID_W-1:0] fid;
   } rpta_mac_t;
endpackage

// ==== rtl/rpta_core.sv ====
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module rpta_core (
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic [rpta_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rpta_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire rpta_pkg::rpta_learn_t learn,
   input wire logic [rpta_pkg::LP_W-1:0] egress_port,
   input wire logic [3:0] fwd_hash,
   input wire logic [rpta_pkg::NPORT-1:0] fwd_dest,
   output logic [rpta_pkg::LP_W-1:0] egress_key_port,
   output logic [rpta_pkg::NPORT-1:0] fwd_ports,
   output logic flush_irq
);
   import rpta_pkg::*;

   // ----------------------------------------------
   // helpers
   // ----------------------------------------------
   function automatic logic [31:0] w65(input logic [NPORT-1:0] v, input logic [1:0] k);
      logic [95:0] t;
      t = {31'h0, v};
      return t[k*32 +: 32];
   endfunction

   function automatic logic [NPORT-1:0] put65(input logic [NPORT-1:0] v,
         input logic [1:0] k, input logic [31:0] d, input logic [3:0] s);
      logic [95:0] t;
      t = {31'h0, v};
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            t[k*32 + b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return t[NPORT-1:0];
   endfunction

   function automatic logic [31:0] mg(input logic [31:0] o, input logic [31:0] d,
         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic hit(input logic [5:0] idx, input logic [5:0] base,
         input logic [5:0] n);
      return idx >= base && idx < base + n;
   endfunction

   // out-of-range ports fold onto port 0 for the per-port tables
   function automatic logic [LP_W-1:0] pidx(input logic [LP_W-1:0] p);
      return (p < LP_W'(NPORT)) ? p : '0;
   endfunction

   // ----------------------------------------------
   // state
   // ----------------------------------------------
   rpta_eng_t upd_state, flush_state;
   logic upd_busy, flush_busy, upd_done, flush_done;
   logic id_list_en, by_id_en, by_port_en, remove_en, grp_en, irq_en;
   logic [VID_W-1:0] upd_start, upd_end, upd_addr, vlan_sel;
   logic [GRP_W-1:0] upd_grp;
   logic [NPORT-1:0] upd_set, upd_sel, flush_ports, fwd_en, lrn_en;
   logic [FID_W-1:0] entry_id;
   logic [FID_W-1:0] id_list [NID];
   logic [GRP_W-1:0] vt_grp [NVID];
   logic [NPORT-1:0] vt_ports [NVID];
   logic [FID_W-1:0] vt_fid [NVID];
   logic [LP_W-1:0] port_sel;
   logic [LP_W-1:0] lrn_lp [NPORT];
   logic [LP_W-1:0] eg_lp [NPORT];
   logic [3:0] agg_sel;
   logic [NPORT-1:0] agg [NAGG];
   logic [MAC_AW-1:0] mac_sel, scan_idx;
   rpta_mac_t mac [NMAC];
   logic [15:0] flush_cnt;
   logic [5:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] rd_word, ctrl_wd;
   logic [5:0] ar_idx;
   logic upd_start_req, flush_start_req, upd_last, upd_match;
   logic [NID-1:0] list_hit;
   logic id_ok, port_ok, scan_hit, learn_ok;
   logic [127:0] fp_ext, le_ext;
   rpta_mac_t cur;

   assign upd_busy = (upd_state == ENG_RUN);
   assign flush_busy = (flush_state == ENG_RUN);
   assign ar_idx = s_axi_araddr[7:2];
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign ctrl_wd = mg(32'h0, w_data, w_strb);
   assign upd_start_req = wr_fire && aw_idx == R_CTRL && ctrl_wd[C_UPD_GO] && !upd_busy;
   assign flush_start_req = wr_fire && aw_idx == R_CTRL && ctrl_wd[C_OP_GO] && !flush_busy;

   // ----------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_idx <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_idx <= s_axi_awaddr[7:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_idx <= R_LAST) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (ar_idx <= R_LAST) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0;
      case (ar_idx)
         // go bits read back as busy until the engine finishes
         R_CTRL: rd_word = {24'h0, irq_en, grp_en, remove_en, by_port_en, by_id_en,
               id_list_en, flush_busy, upd_busy};
         R_STATUS: rd_word = {30'h0, upd_done, flush_done};
         R_RANGE: rd_word = {4'h0, upd_end, 4'h0, upd_start};
         R_UGRP: rd_word = {16'h0, upd_grp};
         R_EID: rd_word = {15'h0, entry_id};
         R_VSEL: rd_word = {20'h0, vlan_sel};
         R_VGRP: rd_word = {16'h0, vt_grp[vlan_sel]};
         R_VFID: rd_word = {15'h0, vt_fid[vlan_sel]};
         R_PSEL: rd_word = {25'h0, port_sel};
         R_PCFG: rd_word = {9'h0, eg_lp[port_sel], 9'h0, lrn_lp[port_sel]};
         R_ASEL: rd_word = {28'h0, agg_sel};
         R_MSEL: rd_word = {26'h0, mac_sel};
         R_MENT: rd_word = {7'h0, mac[mac_sel]};
         R_FCNT: rd_word = {16'h0, flush_cnt};
         default: begin
            if (hit(ar_idx, R_USET, 6'h03)) begin
               rd_word = w65(upd_set, 2'(ar_idx - R_USET));
            end else if (hit(ar_idx, R_USEL, 6'h03)) begin
               rd_word = w65(upd_sel, 2'(ar_idx - R_USEL));
            end else if (hit(ar_idx, R_FPORT, 6'h03)) begin
               rd_word = w65(flush_ports, 2'(ar_idx - R_FPORT));
            end else if (hit(ar_idx, R_VPORT, 6'h03)) begin
               rd_word = w65(vt_ports[vlan_sel], 2'(ar_idx - R_VPORT));
            end else if (hit(ar_idx, R_AMASK, 6'h03)) begin
               rd_word = w65(agg[agg_sel], 2'(ar_idx - R_AMASK));
            end else if (hit(ar_idx, R_FWDEN, 6'h03)) begin
               rd_word = w65(fwd_en, 2'(ar_idx - R_FWDEN));
            end else if (hit(ar_idx, R_LRNEN, 6'h03)) begin
               rd_word = w65(lrn_en, 2'(ar_idx - R_LRNEN));
            end else if (hit(ar_idx, R_ID, 6'(NID))) begin
               rd_word = {15'h0, id_list[4'(ar_idx - R_ID)]};
            end
         end
      endcase
   end

   // ----------------------------------------------
   // configuration registers
   // ----------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         {irq_en, grp_en, remove_en, by_port_en, by_id_en, id_list_en} <= '0;
         upd_start <= '0;
         upd_end <= UPD_END_RST;
         upd_grp <= '0;
         upd_set <= '0;
         upd_sel <= '0;
         flush_ports <= '0;
         // unused value: the single-entry id constrains nothing
         entry_id <= FID_UNUSED;
         vlan_sel <= '0;
         port_sel <= '0;
         agg_sel <= '0;
         mac_sel <= '0;
         fwd_en <= MASK_RST;
         lrn_en <= MASK_RST;
      end else if (ce && wr_fire) begin
         if (aw_idx == R_CTRL) begin
            {irq_en, grp_en, remove_en, by_port_en, by_id_en, id_list_en} <=
                  ctrl_wd[C_IRQ:C_LIST];
         end
         if (aw_idx == R_RANGE) begin
            upd_start <= w_data[VID_W-1:0];
            upd_end <= w_data[RANGE_END_LSB +: VID_W];
         end
         if (aw_idx == R_UGRP) upd_grp <= w_data[GRP_W-1:0];
         if (aw_idx == R_EID) entry_id <= w_data[FID_W-1:0];
         if (aw_idx == R_VSEL) vlan_sel <= w_data[VID_W-1:0];
         if (aw_idx == R_PSEL) port_sel <= pidx(w_data[LP_W-1:0]);
         if (aw_idx == R_ASEL) agg_sel <= w_data[3:0];
         if (aw_idx == R_MSEL) mac_sel <= w_data[MAC_AW-1:0];
         if (hit(aw_idx, R_USET, 6'h03)) begin
            upd_set <= put65(upd_set, 2'(aw_idx - R_USET), w_data, w_strb);
         end
         if (hit(aw_idx, R_USEL, 6'h03)) begin
            upd_sel <= put65(upd_sel, 2'(aw_idx - R_USEL), w_data, w_strb);
         end
         if (hit(aw_idx, R_FPORT, 6'h03)) begin
            flush_ports <= put65(flush_ports, 2'(aw_idx - R_FPORT), w_data, w_strb);
         end
         // standby port is taken out through these enables
         // forward learn enables
         if (hit(aw_idx, R_FWDEN, 6'h03)) begin
            fwd_en <= put65(fwd_en, 2'(aw_idx - R_FWDEN), w_data, w_strb);
         end
         if (hit(aw_idx, R_LRNEN, 6'h03)) begin
            lrn_en <= put65(lrn_en, 2'(aw_idx - R_LRNEN), w_data, w_strb);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < NID; i++) id_list[i] <= FID_UNUSED;
      end else if (ce && wr_fire && hit(aw_idx, R_ID, 6'(NID))) begin
         id_list[4'(aw_idx - R_ID)] <= w_data[FID_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < NAGG; i++) agg[i] <= MASK_RST;
      end else if (ce && wr_fire && hit(aw_idx, R_AMASK, 6'h03)) begin
         agg[agg_sel] <= put65(agg[agg_sel], 2'(aw_idx - R_AMASK), w_data, w_strb);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < NPORT; i++) begin
            lrn_lp[i] <= LP_W'(i);
            eg_lp[i] <= LP_W'(i);
         end
      end else if (ce && wr_fire && aw_idx == R_PCFG) begin
         lrn_lp[port_sel] <= w_data[LP_W-1:0];
         eg_lp[port_sel] <= w_data[PCFG_EG_LSB +: LP_W];
      end
   end

   // ----------------------------------------------
   // vlan table and update engine
   // ----------------------------------------------
   // spare member bits select like group bits
   // member bit selection
   assign upd_match = !grp_en || (|(vt_grp[upd_addr] & upd_grp)) ||
         (|(vt_ports[upd_addr] & upd_sel));
   assign upd_last = upd_addr >= upd_end;

   always_ff @(posedge clock) begin
      if (srst) begin
         upd_state <= ENG_IDLE;
         upd_addr <= '0;
         upd_done <= 1'b0;
      end else if (ce) begin
         case (upd_state)
            ENG_IDLE: begin
               if (upd_start_req) begin
                  upd_addr <= upd_start;
                  upd_state <= ENG_RUN;
               end
            end
            ENG_RUN: begin
               upd_addr <= upd_addr + 1'b1;
               if (upd_last) upd_state <= ENG_IDLE;
            end
            default: upd_state <= ENG_IDLE;
         endcase
         // set wins over a clear in the same cycle
         if (upd_busy && upd_last) begin
            upd_done <= 1'b1;
         end else if (wr_fire && aw_idx == R_STATUS && w_strb[0] && w_data[S_UDONE]) begin
            upd_done <= 1'b0;
         end
      end
   end

   // table writes from software are dropped while the engine runs
   // group and member storage
   always_ff @(posedge clock) begin
      if (ce) begin
         if (upd_busy) begin
            if (upd_match) vt_ports[upd_addr] <= vt_ports[upd_addr] | upd_set;
         end else if (wr_fire) begin
            if (aw_idx == R_VGRP) vt_grp[vlan_sel] <= w_data[GRP_W-1:0];
            if (aw_idx == R_VFID) vt_fid[vlan_sel] <= w_data[FID_W-1:0];
            if (hit(aw_idx, R_VPORT, 6'h03)) begin
               vt_ports[vlan_sel] <= put65(vt_ports[vlan_sel], 2'(aw_idx - R_VPORT),
                     w_data, w_strb);
            end
         end
      end
   end

   // ----------------------------------------------
   // mac table scan and flush engine
   // ----------------------------------------------
   assign cur = mac[scan_idx];
   assign fp_ext = {63'h0, flush_ports};
   assign le_ext = {63'h0, lrn_en};

   generate
      for (genvar g = 0; g < NID; g++) begin : g_list
         assign list_hit[g] = id_list[g] != FID_UNUSED && id_list[g] == cur.fid;
      end
   endgenerate

   assign id_ok = !by_id_en || ((entry_id == FID_UNUSED || entry_id == cur.fid) &&
         (!id_list_en || |list_hit));
   assign port_ok = !by_port_en || fp_ext[cur.lport];
   assign scan_hit = flush_busy && cur.valid && id_ok && port_ok;

   always_ff @(posedge clock) begin
      if (srst) begin
         flush_state <= ENG_IDLE;
         scan_idx <= '0;
         flush_cnt <= '0;
         flush_done <= 1'b0;
      end else if (ce) begin
         case (flush_state)
            ENG_IDLE: begin
               if (flush_start_req) begin
                  scan_idx <= '0;
                  flush_cnt <= '0;
                  flush_state <= ENG_RUN;
               end
            end
            ENG_RUN: begin
               scan_idx <= scan_idx + 1'b1;
               if (scan_hit) flush_cnt <= flush_cnt + 1'b1;
               if (scan_idx == MAC_AW'(NMAC - 1)) flush_state <= ENG_IDLE;
            end
            default: flush_state <= ENG_IDLE;
         endcase
         if (flush_busy && scan_idx == MAC_AW'(NMAC - 1)) begin
            flush_done <= 1'b1;
         end else if (wr_fire && aw_idx == R_STATUS && w_strb[0] && w_data[S_FDONE]) begin
            flush_done <= 1'b0;
         end
      end
   end

   // a fresh learn into the slot being flushed is kept, it is newer
   assign learn_ok = learn.valid && le_ext[learn.port];

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < NMAC; i++) mac[i] <= '0;
      end else if (ce) begin
         if (scan_hit && remove_en) mac[scan_idx].valid <= 1'b0;
         if (learn_ok) mac[learn.slot] <= {1'b1, lrn_lp[pidx(learn.port)], learn.fid};
      end
   end

   // ----------------------------------------------
   // forwarding side outputs
   // ----------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         egress_key_port <= '0;
         fwd_ports <= '0;
         flush_irq <= 1'b0;
      end else if (ce) begin
         egress_key_port <= eg_lp[pidx(egress_port)];
         fwd_ports <= fwd_dest & agg[fwd_hash] & fwd_en;
         flush_irq <= flush_done && irq_en;
      end
   end
endmodule
`default_nettype wire

// ==== dv/rpta_core_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module rpta_chk (
   input wire logic clock,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [rpta_pkg::NPORT-1:0] fwd_dest,
   input wire logic [rpta_pkg::NPORT-1:0] fwd_ports
);
   import rpta_pkg::*;
   // bus timing assumes ce stays high while a transfer is under way
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready)
      else $error("write ready not restored");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_fwd_subset: assert property ((fwd_ports & ~$past(fwd_dest)) == '0)
      else $error("forward port outside candidates");
endmodule
bind rpta_core rpta_chk i_rpta_chk (
   .clock(clock),
   .srst(srst),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .fwd_dest(fwd_dest),
   .fwd_ports(fwd_ports)
);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("FAIL %0t got %h exp %h", $time, a, e); end end
module testbench;
   import rpta_pkg::*;
   logic clock = 1'h0, srst = 1'h1, ce = 1'h1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flush_irq;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf, fwd_hash = 4'h3;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [LP_W-1:0] egress_port = 7'h05, egress_key_port;
   logic [NPORT-1:0] fwd_dest = '1, fwd_ports;
   rpta_learn_t learn = '0;
   // slot 4 carries the unused id and must survive the flush
   rpta_learn_t lt [5] = '{'{1'h1, 7'h05, 17'h14, 6'h0}, '{1'h1, 7'h08, 17'h15, 6'h1},
      '{1'h1, 7'h08, 17'h63, 6'h2}, '{1'h1, 7'h03, 17'h14, 6'h3},
      '{1'h1, 7'h08, 17'h1ffff, 6'h4}};
   int error_cnt = 0, checks = 0;
   rpta_core i_rpta_core (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .learn(learn),
      .egress_port(egress_port),
      .fwd_hash(fwd_hash),
      .fwd_dest(fwd_dest),
      .egress_key_port(egress_key_port),
      .fwd_ports(fwd_ports),
      .flush_irq(flush_irq)
   );
   always #10 clock = ~clock;
   // --------
   // bus tasks
   // --------
   task automatic wr(input logic [5:0] i, input logic [31:0] v);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      // ready stays up between calls so no call lowers and raises it in one step
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [5:0] i);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic final_report;
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200us;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clock);
      srst <= 1'h0;
      @(posedge clock);
      rd(R_RANGE);
      `CHK(d, 32'h0fff_0000)
      rd(R_ID + 6'h0f);
      `CHK(d, 32'h0001_ffff)
      rd(R_EID);
      `CHK(d, 32'h0001_ffff)
      rd(6'h33);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      wr(6'h33, 32'hffff_ffff);
      `CHK(r, RESP_SLVERR)
      // table storage is not reset, so the group word and all three port words are written
      for (int v = 10; v < 13; v++) begin
         wr(R_VSEL, 32'(v));
         wr(R_VGRP, v == 10 ? 32'h2 : v == 11 ? 32'h8000 : 32'h0);
         wr(R_VPORT, 32'h3);
         wr(R_VPORT + 6'h1, 32'h0);
         wr(R_VPORT + 6'h2, {31'h0, v == 12});
      end
      wr(R_RANGE, 32'h000c_000a);
      wr(R_UGRP, 32'h2);
      wr(R_USEL + 6'h2, 32'h1);
      wr(R_USET, 32'h100);
      wr(R_PSEL, 32'h5);
      wr(R_PCFG, 32'h0009_0007);
      foreach (lt[k]) begin
         learn <= lt[k];
         @(posedge clock);
      end
      learn <= '0;
      wr(R_MSEL, 32'h0);
      rd(R_MENT);
      `CHK(d, 32'h010e_0014)
      wr(R_ID, 32'h14);
      wr(R_ID + 6'h1, 32'h15);
      wr(R_FPORT, 32'h180);
      wr(R_CTRL, 32'hff);
      `CHK(r, RESP_OKAY)
      rd(R_CTRL);
      `CHK(d[1], 1'h1)
      for (int n = 0; n < 100 && d[1:0] != 2'h0; n++) rd(R_CTRL);
      `CHK(d[1:0], 2'h0)
      `CHK(flush_irq, 1'h1)
      rd(R_STATUS);
      `CHK(d, 32'h3)
      rd(R_FCNT);
      `CHK(d, 32'h2)
      for (int k = 0; k < 5; k++) begin
         wr(R_MSEL, 32'(k));
         rd(R_MENT);
         `CHK(d[24], k > 1)
      end
      for (int v = 10; v < 13; v++) begin
         wr(R_VSEL, 32'(v));
         rd(R_VPORT);
         `CHK(d, v == 11 ? 32'h3 : 32'h103)
      end
      wr(R_STATUS, 32'h1);
      @(posedge clock);
      `CHK(flush_irq, 1'h0)
      `CHK(egress_key_port, 7'h09)
      rd(R_STATUS);
      `CHK(d, 32'h2)
      wr(R_ASEL, 32'h3);
      wr(R_AMASK, 32'h1);
      wr(R_AMASK + 6'h1, 32'h0);
      wr(R_AMASK + 6'h2, 32'h0);
      @(posedge clock);
      `CHK(fwd_ports, 65'h1)
      // a candidate outside the mask must not reach the output
      fwd_dest <= 65'h1_0000_0000_0000_0000;
      repeat (2) @(posedge clock);
      `CHK(fwd_ports, 65'h0)
      fwd_dest <= '1;
      wr(R_FWDEN, 32'hffff_fffe);
      @(posedge clock);
      `CHK(fwd_ports, 65'h0)
      // clock enable low freezes the egress key
      ce <= 1'h0;
      egress_port <= 7'h03;
      repeat (2) @(posedge clock);
      `CHK(egress_key_port, 7'h09)
      ce <= 1'h1;
      repeat (2) @(posedge clock);
      `CHK(egress_key_port, 7'h03)
      final_report();
   end
endmodule
`default_nettype wire
